// ===== src/usb_out_ep_defines.svh
// Register offsets, field positions, reset values and the function list of the out endpoint block
//
// Function
// - One size byte sets both X and Y buffer capacities identically.
// - Size byte counts eight-byte units; capacity equals value times eight.
// - X buffer start is 11 bits; bits 10:3 come from base byte.
// - Low three bits of X base are forced to zero.
// - Configuration bit 7 enables the out endpoint.
// - Configuration bit 6 selects isochronous, else control, interrupt or bulk.
// - Non-isochronous: toggle bit 5 after a valid packet with matching PID.
// - Configuration bit 4 selects X and Y buffers; zero uses X only.
// - Bit 3 stalls all but setup; overlong control write sets it, interrupts.
// - Configuration bit 2 gates the endpoint interrupt toward the MCU.
// - Good packet into X sets no-acknowledge; non-isochronous NACK until cleared.
`ifndef USB_OUT_EP_DEFINES_SVH
`define USB_OUT_EP_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OEP_OFS_BUF_SIZE 5'h00
`define OEP_OFS_X_BASE 5'h04
`define OEP_OFS_CONFIG 5'h08
`define OEP_OFS_X_COUNT 5'h0C
`define OEP_OFS_INT_STAT 5'h10
`define OEP_OFS_INT_MASK 5'h14

// ****************************************************************
// Configuration byte fields and the count byte no-acknowledge bit
// ****************************************************************
`define OEP_CFG_ENABLE 7
`define OEP_CFG_ISO 6
`define OEP_CFG_TOGGLE 5
`define OEP_CFG_DUAL 4
`define OEP_CFG_STALL 3
`define OEP_CFG_IE 2
`define OEP_CFG_WMASK 8'hFC
`define OEP_CNT_NACK 7

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define OEP_INT_RX 0
`define OEP_INT_STALL 1
`define OEP_INT_WMASK 8'h03

// ****************************************************************
// Reset values and address scaling
// ****************************************************************
`define OEP_RST_BYTE 8'h00
`define OEP_UNIT_SHIFT 3'h3

`endif

// ===== src/usb_out_ep_pkg.sv
// Types shared by the out endpoint configuration and buffer control block
package usb_out_ep_pkg;

  // Handshake answer toward the serial engine
  typedef enum logic [1:0] {
    HS_NONE,
    HS_ACK,
    HS_NAK,
    HS_STALL
  } handshake_t;

  // Token arriving for this endpoint
  typedef struct packed {
    logic valid;
    logic setup;
  } token_t;

  // End of an out data stage
  typedef struct packed {
    logic valid;
    logic pid_ok;
    logic overrun;
    logic [6:0] len;
  } pkt_end_t;

  // Buffer view driven to the buffer manager datapath
  typedef struct packed {
    logic [10:0] x_base;
    logic [10:0] size_bytes;
    logic dual;
  } buf_view_t;

endpackage

// ===== src/usb_out_ep_cfg.sv
// Out endpoint configuration registers, handshake decision and AHB-Lite slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "usb_out_ep_defines.svh"

module usb_out_ep_cfg (
  input wire logic i_ref_clk, // 20 MHz clock
  input wire logic i_sys_rst, // Synchronous reset, active high
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB bus ready
  output logic o_hreadyout, // AHB slave ready
  output logic o_hresp, // AHB response, always OKAY
  output logic [31:0] o_hrdata, // AHB read data
  input wire usb_out_ep_pkg::token_t i_token, // Token for this endpoint
  input wire usb_out_ep_pkg::pkt_end_t i_pkt_end, // Out data stage finished
  output usb_out_ep_pkg::handshake_t o_handshake, // Answer to token, one cycle
  output usb_out_ep_pkg::buf_view_t o_buf_view, // Buffer addresses and mode
  output logic o_irq // Endpoint interrupt, level
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] size_q, size_d;
  logic [7:0] base_q, base_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] mask_q, mask_d;
  logic wr_pend_q, wr_pend_d;
  logic [4:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  usb_out_ep_pkg::handshake_t hs_q, hs_d;
  usb_out_ep_pkg::buf_view_t view_q, view_d;
  logic addr_ok;
  logic [7:0] wbyte;
  logic good_pkt;
  logic hw_stall;
  logic cfg_wr;
  logic cnt_wr;
  logic stat_wr;

  // Address phase accepted while bus ready
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;
  assign wbyte = i_hwdata[7:0];
  // Packet accepted by an enabled endpoint with a matching PID
  assign good_pkt = i_pkt_end.valid && i_pkt_end.pid_ok && cfg_q[`OEP_CFG_ENABLE];
  // Overlong control write on a non-isochronous endpoint
  assign hw_stall = i_pkt_end.valid && i_pkt_end.overrun && !cfg_q[`OEP_CFG_ISO];
  // Software write strobes to registers that hardware also updates
  assign cfg_wr = wr_pend_q && (wr_addr_q == `OEP_OFS_CONFIG);
  assign cnt_wr = wr_pend_q && (wr_addr_q == `OEP_OFS_X_COUNT);
  assign stat_wr = wr_pend_q && (wr_addr_q == `OEP_OFS_INT_STAT);

  // ****************************************************************
  // Bus slave next state
  // ****************************************************************
  always_comb begin
    wr_pend_d = addr_ok && i_hwrite;
    wr_addr_d = addr_ok ? i_haddr[4:0] : wr_addr_q;
    rdata_d = rdata_q;
    if (addr_ok && !i_hwrite) begin
      case (i_haddr[4:0])
        `OEP_OFS_BUF_SIZE: rdata_d = {24'h000000, size_q};
        `OEP_OFS_X_BASE: rdata_d = {24'h000000, base_q};
        `OEP_OFS_CONFIG: rdata_d = {24'h000000, cfg_q};
        `OEP_OFS_X_COUNT: rdata_d = {24'h000000, cnt_q};
        `OEP_OFS_INT_STAT: rdata_d = {24'h000000, stat_q};
        `OEP_OFS_INT_MASK: rdata_d = {24'h000000, mask_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Register next state, hardware updates win over software clears
  // ****************************************************************
  always_comb begin
    size_d = size_q;
    base_d = base_q;
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `OEP_OFS_BUF_SIZE: size_d = wbyte;
        `OEP_OFS_X_BASE: base_d = wbyte;
        `OEP_OFS_CONFIG: cfg_d = wbyte & `OEP_CFG_WMASK;
        `OEP_OFS_X_COUNT: cnt_d = wbyte;
        `OEP_OFS_INT_STAT: stat_d = stat_q & ~(wbyte & `OEP_INT_WMASK);
        `OEP_OFS_INT_MASK: mask_d = wbyte & `OEP_INT_WMASK;
        default: size_d = size_q;
      endcase
    end
    // Good packet lands in X: count and no-acknowledge flag
    if (good_pkt) begin
      cnt_d = {1'b1, i_pkt_end.len};
      stat_d[`OEP_INT_RX] = 1'b1;
      if (!cfg_q[`OEP_CFG_ISO]) begin
        cfg_d[`OEP_CFG_TOGGLE] = ~cfg_d[`OEP_CFG_TOGGLE];
      end
    end
    // Overlong control write stalls the endpoint
    if (hw_stall) begin
      cfg_d[`OEP_CFG_STALL] = 1'b1;
      stat_d[`OEP_INT_STALL] = 1'b1;
    end
  end

  // ****************************************************************
  // Handshake decision and outputs
  // ****************************************************************
  always_comb begin
    hs_d = usb_out_ep_pkg::HS_NONE;
    if (i_token.valid && cfg_q[`OEP_CFG_ENABLE]) begin
      if (cfg_q[`OEP_CFG_STALL] && !i_token.setup) begin
        hs_d = usb_out_ep_pkg::HS_STALL;
      end else if (cnt_q[`OEP_CNT_NACK] && !cfg_q[`OEP_CFG_ISO] && !i_token.setup) begin
        hs_d = usb_out_ep_pkg::HS_NAK;
      end else begin
        hs_d = usb_out_ep_pkg::HS_ACK;
      end
    end
    view_d.x_base = {base_q, 3'b000};
    view_d.size_bytes = {size_q, 3'b000};
    view_d.dual = cfg_q[`OEP_CFG_DUAL];
    irq_d = cfg_q[`OEP_CFG_IE] && |(stat_q & mask_q);
  end

  // Register all state
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      size_q <= `OEP_RST_BYTE;
      base_q <= `OEP_RST_BYTE;
      cfg_q <= `OEP_RST_BYTE;
      cnt_q <= `OEP_RST_BYTE;
      stat_q <= `OEP_RST_BYTE;
      mask_q <= `OEP_RST_BYTE;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 5'h00;
      rdata_q <= 32'h00000000;
      irq_q <= 1'b0;
      hs_q <= usb_out_ep_pkg::HS_NONE;
      view_q <= '0;
    end else begin
      size_q <= size_d;
      base_q <= base_d;
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      hs_q <= hs_d;
      view_q <= view_d;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;
  assign o_handshake = hs_q;
  assign o_buf_view = view_q;
  assign o_irq = irq_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_stall_tok;
    i_token.valid && !i_token.setup && cfg_q[`OEP_CFG_ENABLE] && cfg_q[`OEP_CFG_STALL];
  endsequence

  sequence s_good_nonsiso;
    good_pkt && !cfg_q[`OEP_CFG_ISO] && !cfg_wr;
  endsequence

  sequence s_irq_cause;
    cfg_q[`OEP_CFG_IE] && (stat_q & mask_q) != 8'h00;
  endsequence

  a_stall_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_stall_tok |=> o_handshake == usb_out_ep_pkg::HS_STALL)
    else $error("Stalled endpoint did not answer stall");

  a_setup_passes: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_token.valid && i_token.setup && cfg_q[`OEP_CFG_ENABLE] |=> o_handshake == usb_out_ep_pkg::HS_ACK)
    else $error("Setup token was not accepted");

  a_nack_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_token.valid && !i_token.setup && cfg_q[`OEP_CFG_ENABLE] && !cfg_q[`OEP_CFG_STALL]
    && cnt_q[`OEP_CNT_NACK] && !cfg_q[`OEP_CFG_ISO] |=> o_handshake == usb_out_ep_pkg::HS_NAK)
    else $error("Pending packet did not cause NAK");

  a_iso_no_nak: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cfg_q[`OEP_CFG_ISO] |=> o_handshake != usb_out_ep_pkg::HS_NAK)
    else $error("Isochronous endpoint answered NAK");

  a_disabled_quiet: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !cfg_q[`OEP_CFG_ENABLE] |=> o_handshake == usb_out_ep_pkg::HS_NONE)
    else $error("Disabled endpoint answered a token");

  a_toggle_flip: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_good_nonsiso |=> cfg_q[`OEP_CFG_TOGGLE] != $past(cfg_q[`OEP_CFG_TOGGLE]))
    else $error("Toggle bit did not invert after good packet");

  a_toggle_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !good_pkt && !wr_pend_q |=> $stable(cfg_q[`OEP_CFG_TOGGLE]))
    else $error("Toggle bit changed without cause");

  a_nack_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    good_pkt |=> cnt_q[`OEP_CNT_NACK] && cnt_q[6:0] == $past(i_pkt_end.len))
    else $error("Good packet did not set flag and count");

  a_hw_stall: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    hw_stall |=> cfg_q[`OEP_CFG_STALL] && stat_q[`OEP_INT_STALL])
    else $error("Overrun did not stall the endpoint");

  a_view_addr: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ##1 o_buf_view.x_base == {$past(base_q), 3'b000} && o_buf_view.size_bytes == 11'($past(size_q)) * 11'h008)
    else $error("Buffer view does not follow base and size");

  a_dual_mode: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ##1 o_buf_view.dual == $past(cfg_q[`OEP_CFG_DUAL]))
    else $error("Dual buffer select not reflected");

  a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !cfg_q[`OEP_CFG_IE] |=> !o_irq)
    else $error("Interrupt raised while endpoint interrupt disabled");

  a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cfg_q[1:0] == 2'b00)
    else $error("Reserved configuration bits not zero");

  // ****************************************************************
  // Assertions on answers, hardware updates and the interrupt
  // ****************************************************************
  // Answers to tokens
  a_ack_answer: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_token.valid && cfg_q[`OEP_CFG_ENABLE] && (i_token.setup || (!cfg_q[`OEP_CFG_STALL]
    && (!cnt_q[`OEP_CNT_NACK] || cfg_q[`OEP_CFG_ISO]))) |=> o_handshake == usb_out_ep_pkg::HS_ACK)
    else $error("Open endpoint did not acknowledge");

  a_no_token_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_token.valid |=> o_handshake == usb_out_ep_pkg::HS_NONE)
    else $error("Handshake given without a token");

  a_setup_no_nak: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_token.valid && i_token.setup |=> o_handshake != usb_out_ep_pkg::HS_NAK)
    else $error("Setup token answered NAK");

  // Hardware register updates
  a_rx_status: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    good_pkt |=> stat_q[`OEP_INT_RX])
    else $error("Good packet did not set receive status");

  a_cnt_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !good_pkt && !cnt_wr |=> $stable(cnt_q))
    else $error("Count byte changed without cause");

  a_disabled_no_land: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_pkt_end.valid && !cfg_q[`OEP_CFG_ENABLE] && !cnt_wr |=> $stable(cnt_q))
    else $error("Disabled endpoint took a packet");

  a_iso_toggle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    good_pkt && cfg_q[`OEP_CFG_ISO] && !cfg_wr |=> $stable(cfg_q[`OEP_CFG_TOGGLE]))
    else $error("Isochronous packet changed the toggle bit");

  a_stall_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !hw_stall && !cfg_wr |=> $stable(cfg_q[`OEP_CFG_STALL]))
    else $error("Stall bit changed without cause");

  a_iso_no_stall: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_pkt_end.valid && i_pkt_end.overrun && cfg_q[`OEP_CFG_ISO] && !cfg_wr |=> $stable(cfg_q[`OEP_CFG_STALL]))
    else $error("Isochronous overrun changed the stall bit");

  // Interrupt and buffer view
  a_irq_raise: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_irq_cause |=> o_irq)
    else $error("Unmasked event did not raise the interrupt");

  a_irq_quiet: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (stat_q & mask_q) == 8'h00 |=> !o_irq)
    else $error("Interrupt raised without an unmasked event");

  a_stat_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    stat_wr && wbyte[`OEP_INT_RX] && !good_pkt |=> !stat_q[`OEP_INT_RX])
    else $error("Write of one did not clear receive status");

  a_base_aligned: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_buf_view.x_base[2:0] == 3'b000)
    else $error("X buffer base not on an eight byte boundary");

  a_size_units: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_buf_view.size_bytes[2:0] == 3'b000)
    else $error("Buffer size not a multiple of eight bytes");

endmodule

// ===== sim/usb_host_model.sv
// Behavioural host that sends out tokens and data stage ends to the endpoint
`timescale 1ns/1ps

module usb_host_model (
  input wire logic i_ref_clk, // Clock
  input wire logic i_go, // Start one transaction
  input wire logic i_setup, // Token is a setup token
  input wire usb_out_ep_pkg::pkt_end_t i_pkt, // Data stage result to deliver
  input wire logic [3:0] i_gap, // Cycles from token to data end, at least 1
  output usb_out_ep_pkg::token_t o_token, // Token pulse
  output usb_out_ep_pkg::pkt_end_t o_pkt_end // Data stage end pulse
);
  logic [3:0] cnt_q;

  // Outputs start idle
  initial begin
    o_token = '0;
    o_pkt_end = '0;
    cnt_q = 4'h0;
  end

  // Token first, data stage end later; idle fields change every cycle
  always @(posedge i_ref_clk) begin
    o_token <= {i_go, i_go ? i_setup : ~o_token.setup};
    if (!i_go && cnt_q == 4'h1) begin
      o_pkt_end <= i_pkt;
    end else begin
      o_pkt_end <= {1'b0, ~o_pkt_end[8:0]};
    end
    if (i_go) begin
      cnt_q <= i_gap;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// ===== sim/tb_usb_out_endpoint_buffer_config.sv
// Self-checking bench for the out endpoint configuration block
`timescale 1ns/1ps
`include "usb_out_ep_defines.svh"

module tb_usb_out_endpoint_buffer_config;
  localparam usb_out_ep_pkg::pkt_end_t no_pkt = 10'h000;
  localparam usb_out_ep_pkg::pkt_end_t good_pkt = {3'b110, 7'h2A};
  localparam usb_out_ep_pkg::pkt_end_t bad_pkt = {3'b100, 7'h11};
  localparam usb_out_ep_pkg::pkt_end_t ovr_pkt = {3'b111, 7'h05};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic setup = 1'b0;
  logic [3:0] gap = 4'h1;
  usb_out_ep_pkg::pkt_end_t pkt = 10'h000;
  usb_out_ep_pkg::token_t tok;
  usb_out_ep_pkg::pkt_end_t pend;
  usb_out_ep_pkg::handshake_t hs;
  usb_out_ep_pkg::buf_view_t view;
  logic hrdy;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int miscompares = 0;
  int num_checks = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  usb_out_ep_cfg dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_token(tok), .i_pkt_end(pend), .o_handshake(hs), .o_buf_view(view), .o_irq(irq));

  usb_host_model host_u (.i_ref_clk(clk), .i_go(go), .i_setup(setup), .i_pkt(pkt), .i_gap(gap),
    .o_token(tok), .o_pkt_end(pend));

  // ****************************************************************
  // Compares, bus cycles and transactions
  // ****************************************************************
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_hs(input string n, input usb_out_ep_pkg::handshake_t e, input usb_out_ep_pkg::handshake_t g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input string n, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk_reg(n, {24'h0, e}, rd);
  endtask

  task automatic xact(input logic s, input usb_out_ep_pkg::pkt_end_t p, input logic [3:0] g,
      input usb_out_ep_pkg::handshake_t e);
    go <= 1'b1;
    setup <= s;
    pkt <= p;
    gap <= g;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    chk_hs("handshake", e, hs);
    @(posedge clk);
    chk_hs("handshake idle", usb_out_ep_pkg::HS_NONE, hs);
    repeat (g) @(posedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdc("size", `OEP_OFS_BUF_SIZE, 8'h00);
    rdc("base", `OEP_OFS_X_BASE, 8'h00);
    rdc("config", `OEP_OFS_CONFIG, 8'h00);
    rdc("count", `OEP_OFS_X_COUNT, 8'h00);
    bus(1'b1, 5'h1C, 8'h5A);
    rdc("unmapped", 5'h1C, 8'h00);
    chk_reg("hresp", 32'h0, {31'h0, hresp});
    chk_reg("hreadyout", 32'h1, {31'h0, hrdy});
    chk_reg("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_view();
    bus(1'b1, `OEP_OFS_BUF_SIZE, 8'h18);
    bus(1'b1, `OEP_OFS_X_BASE, 8'hFF);
    bus(1'b1, `OEP_OFS_CONFIG, 8'h13);
    repeat (2) @(posedge clk);
    chk_reg("view", {9'h0, 11'h7F8, 11'h0C0, 1'b1}, view);
    rdc("config", `OEP_OFS_CONFIG, 8'h10);
    bus(1'b1, `OEP_OFS_BUF_SIZE, 8'hFF);
    bus(1'b1, `OEP_OFS_X_BASE, 8'h01);
    bus(1'b1, `OEP_OFS_CONFIG, 8'h00);
    repeat (2) @(posedge clk);
    chk_reg("view", {9'h0, 11'h008, 11'h7F8, 1'b0}, view);
  endtask

  task automatic t_hs();
    xact(1'b0, good_pkt, 4'h1, usb_out_ep_pkg::HS_NONE);
    rdc("count", `OEP_OFS_X_COUNT, 8'h00);
    bus(1'b1, `OEP_OFS_CONFIG, 8'h8B);
    xact(1'b0, no_pkt, 4'h1, usb_out_ep_pkg::HS_STALL);
    xact(1'b1, no_pkt, 4'h1, usb_out_ep_pkg::HS_ACK);
    bus(1'b1, `OEP_OFS_CONFIG, 8'h80);
    bus(1'b1, `OEP_OFS_X_COUNT, 8'h80);
    xact(1'b0, no_pkt, 4'h1, usb_out_ep_pkg::HS_NAK);
    xact(1'b1, no_pkt, 4'h1, usb_out_ep_pkg::HS_ACK);
    bus(1'b1, `OEP_OFS_CONFIG, 8'hC0);
    xact(1'b0, no_pkt, 4'h1, usb_out_ep_pkg::HS_ACK);
    bus(1'b1, `OEP_OFS_X_COUNT, 8'h00);
  endtask

  task automatic t_pkt();
    bus(1'b1, `OEP_OFS_INT_MASK, 8'hFF);
    rdc("mask", `OEP_OFS_INT_MASK, 8'h03);
    bus(1'b1, `OEP_OFS_CONFIG, 8'h84);
    xact(1'b0, good_pkt, 4'h5, usb_out_ep_pkg::HS_ACK);
    chk_reg("irq", 32'h1, {31'h0, irq});
    rdc("count", `OEP_OFS_X_COUNT, 8'hAA);
    rdc("config", `OEP_OFS_CONFIG, 8'hA4);
    bus(1'b1, `OEP_OFS_INT_STAT, 8'h01);
    rdc("status", `OEP_OFS_INT_STAT, 8'h00);
    chk_reg("irq", 32'h0, {31'h0, irq});
    xact(1'b0, bad_pkt, 4'h1, usb_out_ep_pkg::HS_NAK);
    rdc("config", `OEP_OFS_CONFIG, 8'hA4);
    bus(1'b1, `OEP_OFS_X_COUNT, 8'h00);
    bus(1'b1, `OEP_OFS_INT_MASK, 8'h00);
    xact(1'b0, good_pkt, 4'h1, usb_out_ep_pkg::HS_ACK);
    chk_reg("irq", 32'h0, {31'h0, irq});
    rdc("status", `OEP_OFS_INT_STAT, 8'h01);
    rdc("config", `OEP_OFS_CONFIG, 8'h84);
    bus(1'b1, `OEP_OFS_X_COUNT, 8'h00);
    bus(1'b1, `OEP_OFS_CONFIG, 8'hC4);
    xact(1'b0, ovr_pkt, 4'h1, usb_out_ep_pkg::HS_ACK);
    rdc("config", `OEP_OFS_CONFIG, 8'hC4);
    bus(1'b1, `OEP_OFS_X_COUNT, 8'h00);
    bus(1'b1, `OEP_OFS_INT_MASK, 8'h02);
    bus(1'b1, `OEP_OFS_CONFIG, 8'h84);
    xact(1'b0, ovr_pkt, 4'h1, usb_out_ep_pkg::HS_ACK);
    rdc("config", `OEP_OFS_CONFIG, 8'hAC);
    rdc("status", `OEP_OFS_INT_STAT, 8'h03);
    chk_reg("irq", 32'h1, {31'h0, irq});
    bus(1'b1, `OEP_OFS_CONFIG, 8'h80);
    repeat (2) @(posedge clk);
    chk_reg("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_view();
    t_hs();
    t_pkt();
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule
